// ### rtl/acpc_consts.svh
`ifndef ACPC_CONSTS_SVH
`define ACPC_CONSTS_SVH

// Register byte offsets
`define ACPC_OFF_MODE0   32'h00000000
`define ACPC_OFF_MODE1   32'h00000004
`define ACPC_OFF_MODE2   32'h00000008
`define ACPC_OFF_ISTAT   32'h0000000C
`define ACPC_OFF_ICLR    32'h00000010
`define ACPC_OFF_IEN     32'h00000014
// Mode register zero fields
`define ACPC_M0_START    0
`define ACPC_M0_SCAN     1
`define ACPC_M0_NBUSY    6
// Mode register one fields
`define ACPC_M1_REF      7
`define ACPC_M1_IDLE     6
`define ACPC_M1_SCNW_LSB 4
// Mode register two fields
`define ACPC_M2_DONE     7
`define ACPC_M2_BUSY     6
`define ACPC_M2_START    5
// Interrupt status bits
`define ACPC_IRQ_PRIO    0
`define ACPC_IRQ_SCAN    1
// Reset values and limits
`define ACPC_RST_BYTE    8'h00
`define ACPC_CH_MAX12    4'hB
`define ACPC_RESP_OKAY   2'h0
`define ACPC_RESP_SLVERR 2'h2
`endif

// ### rtl/acpc_pkg.sv
package acpc_pkg;
	// Sequencer states
	typedef enum logic [1:0] {
		ACPC_ST_IDLE = 2'b00,
		ACPC_ST_NORM = 2'b01,
		ACPC_ST_PRIO = 2'b10
	} acpc_state_t;
	// Scan width codes
	typedef enum logic [1:0] {
		ACPC_SCAN4    = 2'b00,
		ACPC_SCAN8    = 2'b01,
		ACPC_SCAN12   = 2'b10,
		ACPC_SCAN_RSV = 2'b11
	} acpc_scanw_t;
	// Analog input number
	typedef logic [3:0] acpc_chan_t;
endpackage

// ### rtl/acpc_top.sv
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "acpc_consts.svh"
module acpc_top (
	input  wire logic               clk_sys,
	input  wire logic               reset_n,
	input  wire logic [31:0]        s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output var  logic               s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output var  logic               s_axi_wready,
	output var  logic [1:0]         s_axi_bresp,
	output var  logic               s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [31:0]        s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output var  logic               s_axi_arready,
	output var  logic [31:0]        s_axi_rdata,
	output var  logic [1:0]         s_axi_rresp,
	output var  logic               s_axi_rvalid,
	input  wire logic               s_axi_rready,
	input  wire logic               system_idle,
	input  wire logic               cnv_done,
	output var  logic               ref_enable,
	output var  logic               cnv_enable,
	output var  logic               cnv_start,
	output var  logic               cnv_priority,
	output var  acpc_pkg::acpc_chan_t cnv_channel,
	output var  logic               irq
);
	import acpc_pkg::*;

	// First scanned input for the current mode
	function automatic acpc_chan_t scan_first(input logic scan, input acpc_scanw_t w,
		input acpc_chan_t ch);
		scan_first = (scan && (w == ACPC_SCAN8 || w == ACPC_SCAN12)) ? 4'h0 :
			scan ? {1'b0, ch[2], 2'b00} : ch;
	endfunction

	// Last scanned input; undefined 12-channel codes clamp to the top input
	function automatic acpc_chan_t scan_last(input logic scan, input acpc_scanw_t w,
		input acpc_chan_t ch);
		scan_last = !scan ? ch : (w != ACPC_SCAN12) ? {1'b0, ch[2:0]} :
			(ch > `ACPC_CH_MAX12) ? `ACPC_CH_MAX12 : ch;
	endfunction

	// Register state
	logic        m0_scan_reg;     // Scan select
	logic [7:0]  m1_reg;          // Reference, idle, width, channel
	acpc_chan_t  m2_ch_reg;       // Priority channel
	logic        prio_busy_reg;   // Priority conversion under way
	logic        prio_done_reg;   // Priority completion, clear on read
	logic        prio_pend_reg;   // Priority launch waiting
	logic        norm_active_reg; // Normal sequence running
	acpc_chan_t  cur_ch_reg;      // Normal channel in progress
	acpc_state_t state_reg;       // Sequencer state
	acpc_state_t state_next;
	logic [1:0]  int_stat_reg;    // Sticky events
	logic [1:0]  int_en_reg;      // Event enables
	// Bus capture
	logic        aw_ok_reg;
	logic        w_ok_reg;
	logic [31:0] waddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  wstrb_reg;
	// Completion synchroniser
	logic        done_s1_reg;
	logic        done_s2_reg;
	logic        done_s3_reg;

	// Bus handshakes
	wire aw_hs      = s_axi_awvalid & s_axi_awready;
	wire w_hs       = s_axi_wvalid & s_axi_wready;
	wire ar_hs      = s_axi_arvalid & s_axi_arready;
	wire wr_do      = aw_ok_reg & w_ok_reg & ~s_axi_bvalid;
	wire aw_ok_next = (aw_ok_reg | aw_hs) & ~wr_do;
	wire w_ok_next  = (w_ok_reg | w_hs) & ~wr_do;
	wire rv_next    = ar_hs | (s_axi_rvalid & ~s_axi_rready);
	wire wr_lane0   = wr_do & wstrb_reg[0];

	// Write decode
	wire wa_m0  = waddr_reg == `ACPC_OFF_MODE0;
	wire wa_m1  = waddr_reg == `ACPC_OFF_MODE1;
	wire wa_m2  = waddr_reg == `ACPC_OFF_MODE2;
	wire wa_clr = waddr_reg == `ACPC_OFF_ICLR;
	wire wa_en  = waddr_reg == `ACPC_OFF_IEN;
	wire wa_hit = wa_m0 | wa_m1 | wa_m2 | wa_clr | wa_en | (waddr_reg == `ACPC_OFF_ISTAT);

	// Read decode
	wire ra_m0  = s_axi_araddr == `ACPC_OFF_MODE0;
	wire ra_m1  = s_axi_araddr == `ACPC_OFF_MODE1;
	wire ra_m2  = s_axi_araddr == `ACPC_OFF_MODE2;
	wire ra_st  = s_axi_araddr == `ACPC_OFF_ISTAT;
	wire ra_en  = s_axi_araddr == `ACPC_OFF_IEN;
	wire ra_hit = ra_m0 | ra_m1 | ra_m2 | ra_st | ra_en | (s_axi_araddr == `ACPC_OFF_ICLR);

	// Start strobes; writing zero does nothing
	wire norm_wr = wr_lane0 & wa_m0 & wdata_reg[`ACPC_M0_START];
	wire prio_wr = wr_lane0 & wa_m2 & wdata_reg[`ACPC_M2_START];
	wire rd_m2   = ar_hs & ra_m2;

	// Mode fields
	wire         ref_on   = m1_reg[`ACPC_M1_REF];
	wire         idle_op  = m1_reg[`ACPC_M1_IDLE];
	acpc_scanw_t scan_w;
	assign scan_w = acpc_scanw_t'(m1_reg[`ACPC_M1_SCNW_LSB +: 2]);
	wire acpc_chan_t ch_field = m1_reg[3:0];
	wire acpc_chan_t first_ch = scan_first(m0_scan_reg, scan_w, ch_field);
	wire acpc_chan_t last_ch  = scan_last(m0_scan_reg, scan_w, ch_field);
	// Converter may run unless system idles without idle operation
	wire run_ok   = ~system_idle | idle_op;
	wire done_evt = done_s2_reg & ~done_s3_reg;
	wire seq_end  = done_evt & (state_reg == ACPC_ST_NORM) & (cur_ch_reg == last_ch);
	wire prio_end = done_evt & (state_reg == ACPC_ST_PRIO);
	// Read word; high bits and start bits are zero
	wire [7:0] rd_byte = ra_m0 ? {1'b0, norm_active_reg, 4'h0, m0_scan_reg, 1'b0} :
		ra_m1 ? m1_reg :
		ra_m2 ? {prio_done_reg, prio_busy_reg, 2'b00, m2_ch_reg} :
		ra_st ? {6'h00, int_stat_reg} :
		ra_en ? {6'h00, int_en_reg} : `ACPC_RST_BYTE;

	// Sequencer: priority launches ahead of the next normal channel
	logic       launch;
	logic       launch_prio;
	acpc_chan_t launch_ch;
	always_comb begin
		state_next  = state_reg;
		launch      = 1'b0;
		launch_prio = 1'b0;
		launch_ch   = cur_ch_reg;
		case (state_reg)
			ACPC_ST_IDLE: begin
				if (run_ok && prio_pend_reg) begin
					launch      = 1'b1;
					launch_prio = 1'b1;
					launch_ch   = m2_ch_reg;
					state_next  = ACPC_ST_PRIO;
				end else if (run_ok && norm_active_reg) begin
					launch     = 1'b1;
					state_next = ACPC_ST_NORM;
				end
			end
			ACPC_ST_NORM, ACPC_ST_PRIO: begin
				if (done_evt) begin
					state_next = ACPC_ST_IDLE;
				end
			end
			default: state_next = ACPC_ST_IDLE;
		endcase
	end

	// Bus handshake flops
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			aw_ok_reg     <= 1'b0;
			w_ok_reg      <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_arready <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_rvalid  <= 1'b0;
		end else begin
			aw_ok_reg     <= aw_ok_next;
			w_ok_reg      <= w_ok_next;
			s_axi_awready <= ~aw_ok_next;
			s_axi_wready  <= ~w_ok_next;
			s_axi_arready <= ~rv_next;
			s_axi_bvalid  <= wr_do | (s_axi_bvalid & ~s_axi_bready);
			s_axi_rvalid  <= rv_next;
		end
	end

	// Bus payload flops
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			waddr_reg   <= 32'h00000000;
			wdata_reg   <= 32'h00000000;
			wstrb_reg   <= 4'h0;
			s_axi_bresp <= `ACPC_RESP_OKAY;
			s_axi_rresp <= `ACPC_RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
		end else begin
			if (aw_hs) waddr_reg <= s_axi_awaddr;
			if (w_hs) begin
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			// Unmapped addresses answer with a slave error
			if (wr_do) s_axi_bresp <= wa_hit ? `ACPC_RESP_OKAY : `ACPC_RESP_SLVERR;
			if (ar_hs) begin
				s_axi_rdata <= {24'h000000, rd_byte};
				s_axi_rresp <= ra_hit ? `ACPC_RESP_OKAY : `ACPC_RESP_SLVERR;
			end
		end
	end

	// Mode registers; bit 4 of mode two is not stored
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			m0_scan_reg <= 1'b0;
			m1_reg      <= `ACPC_RST_BYTE;
			m2_ch_reg   <= 4'h0;
			int_en_reg  <= 2'h0;
		end else begin
			if (wr_lane0 && wa_m0) m0_scan_reg <= wdata_reg[`ACPC_M0_SCAN];
			if (wr_lane0 && wa_m1) m1_reg <= wdata_reg[7:0];
			if (wr_lane0 && wa_m2) m2_ch_reg <= wdata_reg[3:0];
			if (wr_lane0 && wa_en) int_en_reg <= wdata_reg[1:0];
		end
	end

	// Priority flags; a new event wins over a clear
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			prio_pend_reg <= 1'b0;
			prio_busy_reg <= 1'b0;
			prio_done_reg <= 1'b0;
		end else begin
			// A start while busy is dropped, not queued twice
			if (prio_wr && !prio_busy_reg) prio_pend_reg <= 1'b1;
			else if (launch_prio) prio_pend_reg <= 1'b0;
			// Only an idle path takes a start, so a start in the done cycle cannot hang busy
			if (prio_wr && !prio_busy_reg) prio_busy_reg <= 1'b1;
			else if (prio_end) prio_busy_reg <= 1'b0;
			if (prio_end) prio_done_reg <= 1'b1;
			else if (rd_m2 || prio_wr) prio_done_reg <= 1'b0;
		end
	end

	// Normal sequence walk from first to last channel
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			norm_active_reg <= 1'b0;
			cur_ch_reg      <= 4'h0;
			state_reg       <= ACPC_ST_IDLE;
		end else begin
			state_reg <= state_next;
			if (norm_wr && !norm_active_reg) begin
				norm_active_reg <= 1'b1;
				cur_ch_reg      <= first_ch;
			end else if (seq_end) begin
				norm_active_reg <= 1'b0;
			end else if (done_evt && state_reg == ACPC_ST_NORM) begin
				cur_ch_reg <= cur_ch_reg + 4'h1;
			end
		end
	end

	// Interrupt status; set wins over a write-one clear
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			int_stat_reg <= 2'h0;
			irq          <= 1'b0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if ((i == `ACPC_IRQ_PRIO) ? prio_end : seq_end) int_stat_reg[i] <= 1'b1;
				else if (wr_lane0 && wa_clr && wdata_reg[i]) int_stat_reg[i] <= 1'b0;
			end
			irq <= |(int_stat_reg & int_en_reg);
		end
	end

	// Converter drive and completion synchroniser
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			ref_enable   <= 1'b0;
			cnv_enable   <= 1'b0;
			cnv_start    <= 1'b0;
			cnv_priority <= 1'b0;
			cnv_channel  <= 4'h0;
			done_s1_reg  <= 1'b0;
			done_s2_reg  <= 1'b0;
			done_s3_reg  <= 1'b0;
		end else begin
			ref_enable  <= ref_on;
			cnv_enable  <= run_ok;
			cnv_start   <= launch;
			done_s1_reg <= cnv_done;
			done_s2_reg <= done_s1_reg;
			done_s3_reg <= done_s2_reg;
			if (launch) begin
				cnv_priority <= launch_prio;
				cnv_channel  <= launch_ch;
			end
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// Reference follows its bit two edges after the write
	property p_ref;
		wr_lane0 && wa_m1 |-> ##2 ref_enable == $past(wdata_reg[`ACPC_M1_REF], 2);
	endproperty
	a_ref: assert property (p_ref) else $error("reference enable wrong");
	property p_idle;
		system_idle && !idle_op |=> !cnv_enable && !cnv_start;
	endproperty
	a_idle: assert property (p_idle) else $error("converter ran in idle");
	property p_done;
		prio_end |=> prio_done_reg && !prio_busy_reg;
	endproperty
	a_done: assert property (p_done) else $error("priority done not set");
	property p_busy;
		prio_wr && !prio_end |=> prio_busy_reg && !prio_done_reg;
	endproperty
	a_busy: assert property (p_busy) else $error("priority busy not set");
	property p_rd_zero;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("upper bits not zero");
	property p_start_zero;
		ar_hs |=> !($past(ra_m0) && s_axi_rdata[`ACPC_M0_START])
			&& !($past(ra_m2) && s_axi_rdata[`ACPC_M2_START]);
	endproperty
	a_start_zero: assert property (p_start_zero) else $error("start bit read as one");
	property p_fixed;
		launch && !launch_prio && !m0_scan_reg |=> cnv_start && cnv_channel == $past(ch_field);
	endproperty
	a_fixed: assert property (p_fixed) else $error("fixed channel wrong");
	property p_scan_rng;
		launch && !launch_prio && m0_scan_reg |-> launch_ch <= last_ch && launch_ch >= first_ch;
	endproperty
	a_scan_rng: assert property (p_scan_rng) else $error("scan channel out of range");
	property p_prio_ch;
		launch_prio |=> cnv_priority && cnv_channel == $past(m2_ch_reg);
	endproperty
	a_prio_ch: assert property (p_prio_ch) else $error("priority channel wrong");
	property p_first;
		norm_wr && !norm_active_reg |=> cur_ch_reg == $past(first_ch);
	endproperty
	a_first: assert property (p_first) else $error("scan start channel wrong");
	c_prio: cover property (prio_wr ##[1:50] prio_end);
	c_scan: cover property (norm_wr && m0_scan_reg ##[1:200] seq_end);
	c_irq: cover property (irq && int_stat_reg[`ACPC_IRQ_SCAN]);
endmodule
`default_nettype wire

// ### bench/acpc_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stand-in for the converter core
module acpc_conv_model (
	input  wire logic clk_sys,
	input  wire logic reset_n,
	input  wire logic cnv_start,
	input  wire logic cnv_enable,
	input  wire logic slow,
	output var  logic cnv_done
);
	logic [5:0] cnt_reg;  // Cycles left in the running conversion
	logic [1:0] hold_reg; // Remaining cycles of the done level
	// Done rises only after a launch and is low between completions
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			cnt_reg <= 6'h00;
			hold_reg <= 2'h0;
			cnv_done <= 1'b0;
		end else begin
			// A stopped core makes no progress, so a long idle stall is visible
			if (cnv_start)
				cnt_reg <= slow ? 6'h0F : 6'h02;
			else if (cnt_reg != 6'h00 && cnv_enable)
				cnt_reg <= cnt_reg - 6'h01;
			if (cnt_reg == 6'h01 && cnv_enable && !cnv_start)
				hold_reg <= 2'h2;
			else if (hold_reg != 2'h0)
				hold_reg <= hold_reg - 2'h1;
			cnv_done <= (hold_reg != 2'h0);
		end
	end
endmodule
`default_nettype wire

// ### bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "acpc_consts.svh"
module testbench;
	import acpc_pkg::*;
	logic        clk_sys = 1'b0;           // 10 MHz system clock
	logic        reset_n = 1'b0;           // Active-low reset
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, irq, ref_en, cnv_en, cnv_start, cnv_prio;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	acpc_chan_t  cnv_ch;
	logic        sys_idle = 1'b0, slow = 1'b0, cnv_done;
	logic [4:0]  seen_q[$];                // Launches seen: priority, channel
	int          n_errors = 0;
	int          samples_checked = 0;
	logic [31:0] rd;                       // Last read data
	logic [1:0]  rs;                       // Last response code
	logic [7:0]  rng;
	logic        scn;
	logic [1:0]  sw;
	logic [3:0]  ch;
	// Free-running system clock
	always #50 clk_sys = ~clk_sys;
	acpc_top u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.system_idle(sys_idle), .cnv_done(cnv_done), .ref_enable(ref_en), .cnv_enable(cnv_en),
		.cnv_start(cnv_start), .cnv_priority(cnv_prio), .cnv_channel(cnv_ch), .irq(irq));
	acpc_conv_model u_conv (.clk_sys(clk_sys), .reset_n(reset_n), .cnv_start(cnv_start),
		.cnv_enable(cnv_en), .slow(slow), .cnv_done(cnv_done));
	// Log every launch with its channel
	always @(posedge clk_sys) if (reset_n && cnv_start) seen_q.push_back({cnv_prio, cnv_ch});
	task automatic stop_test();
		$display("Checks %0d, errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// A hung handshake or poll ends the run
	task automatic guard(input int n);
		if (n > 300) begin
			n_errors++;
			stop_test();
		end
	endtask
	// Address and data offered together, each released once taken
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			n++;
			guard(n);
		end while (!bvalid);
		bready <= 1'b0;
		rs = bresp;
	endtask
	task automatic rdr(input logic [31:0] a);
		int n;
		n = 0;
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (arready) arvalid <= 1'b0;
			n++;
			guard(n);
		end while (!rvalid);
		rready <= 1'b0;
		rd = rdata;
		rs = rresp;
	endtask
	// Poll the sticky status until the event bit shows
	task automatic wait_stat(input int b);
		int n;
		n = 0;
		do begin
			rdr(`ACPC_OFF_ISTAT);
			n++;
			guard(n);
		end while (rd[b] !== 1'b1);
	endtask
	// First and last input of a sequence
	function automatic logic [7:0] exp_range(input logic s, input logic [1:0] w, input logic [3:0] c);
		if (!s) return {c, c};
		case (w)
			2'b01: return {5'h00, c[2:0]};
			2'b10: return {4'h0, (c > 4'hB) ? 4'hB : c};
			default: return {1'b0, c[2], 3'h0, c[2], c[1:0]};
		endcase
	endfunction
	initial begin
		void'($urandom(32'h88ED));
		repeat (8) @(posedge clk_sys);
		reset_n <= 1'b1;
		// Reset values and the unmapped hole
		rdr(`ACPC_OFF_MODE0);
		check(rd, 32'h0);
		rdr(`ACPC_OFF_MODE1);
		check(rd, 32'h0);
		rdr(`ACPC_OFF_MODE2);
		check(rd, 32'h0);
		rdr(32'h00000040);
		check(rs, `ACPC_RESP_SLVERR);
		check(rd, 32'h0);
		wr(32'h00000040, 32'hFFFFFFFF);
		check(rs, `ACPC_RESP_SLVERR);
		// Upper bits read zero, ignored bit and a zero start
		wr(`ACPC_OFF_MODE1, 32'hFFFFFFFF);
		check(rs, `ACPC_RESP_OKAY);
		rdr(`ACPC_OFF_MODE1);
		check(rd, 32'hFF);
		check(rs, `ACPC_RESP_OKAY);
		wr(`ACPC_OFF_MODE2, 32'hFFFFFF1F);
		rdr(`ACPC_OFF_MODE2);
		check(rd, 32'h0F);
		// Reference and idle behaviour
		sys_idle <= 1'b1;
		wr(`ACPC_OFF_MODE1, 32'h80);
		repeat (2) @(posedge clk_sys);
		check({ref_en, cnv_en}, 32'h2);
		wr(`ACPC_OFF_MODE1, 32'h40);
		repeat (2) @(posedge clk_sys);
		check({ref_en, cnv_en}, 32'h1);
		sys_idle <= 1'b0;
		wr(`ACPC_OFF_MODE1, 32'h80);
		repeat (30) @(posedge clk_sys);
		check(cnv_en, 32'h1);
		// Normal sequences over every mode and legal width code
		for (int i = 0; i < 12; i++) begin
			rng = 8'($urandom);
			scn = (i > 1);
			sw = 2'(i % 3);                 // Reserved width code is never written
			ch = (i == 5) ? 4'hF : rng[3:0]; // Undefined 12-channel code clamps
			slow <= rng[4];
			wr(`ACPC_OFF_MODE1, {24'h0, 2'b10, sw, ch});
			// Mode settles in its own write ahead of the start
			wr(`ACPC_OFF_MODE0, {30'h0, scn, 1'b0});
			seen_q.delete();
			wr(`ACPC_OFF_MODE0, {30'h0, scn, 1'b1});
			wait_stat(1);
			rdr(`ACPC_OFF_MODE0);
			check(rd, {30'h0, scn, 1'b0});
			rng = exp_range(scn, sw, ch);
			check(seen_q.size(), 32'(rng[3:0]) - 32'(rng[7:4]) + 1);
			foreach (seen_q[k]) check(seen_q[k], 32'(rng[7:4]) + k);
			check(irq, 32'h0);
			wr(`ACPC_OFF_ICLR, 32'h2);
		end
		// Priority conversions with the interrupt enabled
		wr(`ACPC_OFF_IEN, 32'h1);
		for (int i = 0; i < 3; i++) begin
			ch = 4'($urandom);
			slow <= 1'b1;
			seen_q.delete();
			wr(`ACPC_OFF_MODE2, {24'h0, 4'h2, ch});
			rdr(`ACPC_OFF_MODE2);
			check(rd, {24'h0, 4'h4, ch});
			wait_stat(0);
			check(irq, 32'h1);
			rdr(`ACPC_OFF_MODE2);
			check(rd, {24'h0, 4'h8, ch});
			rdr(`ACPC_OFF_MODE2);
			check(rd, {24'h0, 4'h0, ch});
			check(seen_q[0], {1'b1, ch});
			wr(`ACPC_OFF_ICLR, 32'h1);
			repeat (2) @(posedge clk_sys);
			check(irq, 32'h0);
		end
		stop_test();
	end
endmodule
`default_nettype wire
